/* verilog/swp_core.sv */
// sector write protection: lock registers, block protect, link bridge
`timescale 1ns/10ps

module swp_core
  import swp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic link_req_valid_in,
  input wire swp_req_s link_req_in,
  output logic link_busy_out,
  output logic link_done_out,
  output swp_rsp_s link_rsp_out,
  input wire logic write_protect_n_in,
  output logic modify_grant_out,
  output logic [SWP_ADDR_W-1:0] modify_addr_out,
  output logic modify_erase_out,
  output logic prot_error_out,
  output logic write_enable_latch_out,
  output logic status_frozen_out
);

  // ********************************************************************
  // link domain: request capture and answer return
  // ********************************************************************

  swp_req_s lnk_req_q;
  logic lnk_req_tgl_q;
  logic lnk_busy_q;
  logic lnk_ack_s;
  logic lnk_ack_seen_q;
  logic lnk_done_q;
  swp_rsp_s lnk_rsp_q;

  // core side toggle, answer word is held stable until the next request
  logic core_ack_tgl_q;
  swp_rsp_s core_rsp_q;

  swp_sync #(.RESET_VAL(1'b0)) u_ack_sync (
    .clk_in(link_clk_in),
    .rstn_in(rstn_in),
    .d_in(core_ack_tgl_q),
    .q_out(lnk_ack_s)
  );

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk_req_q <= '0;
      lnk_req_tgl_q <= 1'b0;
    end else if (link_req_valid_in && !lnk_busy_q) begin
      lnk_req_q <= link_req_in;
      lnk_req_tgl_q <= !lnk_req_tgl_q;
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk_ack_seen_q <= 1'b0;
    end else begin
      lnk_ack_seen_q <= lnk_ack_s;
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk_busy_q <= 1'b0;
    end else if (link_req_valid_in && !lnk_busy_q) begin
      lnk_busy_q <= 1'b1;
    end else if (lnk_ack_s != lnk_ack_seen_q) begin
      lnk_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk_done_q <= 1'b0;
      lnk_rsp_q <= '0;
    end else begin
      lnk_done_q <= lnk_ack_s != lnk_ack_seen_q;
      if (lnk_ack_s != lnk_ack_seen_q) begin
        lnk_rsp_q <= core_rsp_q;
      end
    end
  end

  assign link_busy_out = lnk_busy_q;
  assign link_done_out = lnk_done_q;
  assign link_rsp_out = lnk_rsp_q;

  // ********************************************************************
  // core domain: request pickup
  // ********************************************************************

  typedef enum logic [1:0] {
    SWP_CS_IDLE = 2'b00,
    SWP_CS_EXEC = 2'b01
  } swp_cs_e;

  swp_cs_e cs_q;
  logic core_req_s;
  logic core_req_seen_q;
  logic wp_n_s;
  swp_req_s cmd_q;

  swp_sync #(.RESET_VAL(1'b0)) u_req_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(lnk_req_tgl_q),
    .q_out(core_req_s)
  );

  // the pin idles high, so reset to the unprotected level
  swp_sync #(.RESET_VAL(1'b1)) u_wp_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(write_protect_n_in),
    .q_out(wp_n_s)
  );

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_req_seen_q <= 1'b0;
    end else begin
      core_req_seen_q <= core_req_s;
    end
  end

  // link request word is stable here: it only changes after the answer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_q <= SWP_CS_IDLE;
      cmd_q <= '0;
    end else begin
      unique case (cs_q)
        SWP_CS_IDLE: begin
          if (core_req_s != core_req_seen_q) begin
            cmd_q <= lnk_req_q;
            cs_q <= SWP_CS_EXEC;
          end
        end
        SWP_CS_EXEC: begin
          cs_q <= SWP_CS_IDLE;
        end
        default: begin
          cs_q <= SWP_CS_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // core domain: protection state and decisions
  // ********************************************************************

  logic [1:0] lock_q [SWP_SECTORS];
  logic [SWP_CODE_W-1:0] prot_code_q;
  logic top_bottom_select_q;
  logic status_write_disable_q;
  logic write_enable_latch_q;
  logic prot_err_q;

  logic exec;
  logic [SWP_SEC_W-1:0] sector;
  logic [1:0] cur_lock;
  logic bp_prot;
  logic sec_prot;
  logic sr_frozen;
  logic is_modify;
  logic modify_ok;
  logic modify_bad;
  logic status_write_instr_bad;

  assign exec = cs_q == SWP_CS_EXEC;
  assign sector = swp_sector(cmd_q.addr);
  assign cur_lock = lock_q[sector];

  swp_region u_region (
    .code_in(prot_code_q),
    .top_bottom_select_in(top_bottom_select_q),
    .sector_in(sector),
    .protected_out(bp_prot)
  );

  // either scheme alone is enough to protect the sector
  assign sec_prot = cur_lock[SWP_LR_WLOCK] || bp_prot;
  assign sr_frozen = status_write_disable_q && !wp_n_s;
  assign is_modify = cmd_q.op == SWP_OP_PROG || cmd_q.op == SWP_OP_ERAS;
  assign modify_ok = exec && is_modify && write_enable_latch_q && !sec_prot;
  assign modify_bad = exec && is_modify && write_enable_latch_q && sec_prot;
  assign status_write_instr_bad = exec && cmd_q.op == SWP_OP_STATUS_WRITE_INSTR && write_enable_latch_q
                    && sr_frozen;

  genvar gi;
  generate
    for (gi = 0; gi < SWP_SECTORS; gi++) begin : g_lock
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          lock_q[gi] <= SWP_LR_RESET;
        end else if (exec && cmd_q.op == SWP_OP_LOCK_WRITE_INSTR
                     && write_enable_latch_q
                     && sector == SWP_SEC_W'(gi)
                     && !lock_q[gi][SWP_LR_LDOWN]) begin
          lock_q[gi] <= cmd_q.wdata[1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prot_code_q <= SWP_CODE_RESET;
      top_bottom_select_q <= 1'b0;
      status_write_disable_q <= 1'b0;
    end else if (exec && cmd_q.op == SWP_OP_STATUS_WRITE_INSTR
                 && write_enable_latch_q && !sr_frozen) begin
      prot_code_q <= {cmd_q.wdata[SWP_SR_B3], cmd_q.wdata[SWP_SR_B2],
                      cmd_q.wdata[SWP_SR_B1], cmd_q.wdata[SWP_SR_B0]};
      top_bottom_select_q <= cmd_q.wdata[SWP_SR_TB];
      status_write_disable_q <= cmd_q.wdata[SWP_SR_STATUS_WRITE_DISABLE];
    end
  end

  // latch is dropped by every modifying instruction once it completes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      write_enable_latch_q <= 1'b0;
    end else if (exec) begin
      unique case (cmd_q.op)
        SWP_OP_WRITE_ENABLE_INSTR: write_enable_latch_q <= 1'b1;
        SWP_OP_WRDI, SWP_OP_STATUS_WRITE_INSTR, SWP_OP_PROG, SWP_OP_ERAS: begin
          write_enable_latch_q <= 1'b0;
        end
        SWP_OP_LOCK_WRITE_INSTR: write_enable_latch_q <= 1'b0;
        default: write_enable_latch_q <= write_enable_latch_q;
      endcase
    end
  end

  // a refusal in the same cycle as a clear keeps the flag set
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prot_err_q <= 1'b0;
    end else if (modify_bad || status_write_instr_bad) begin
      prot_err_q <= 1'b1;
    end else if (exec && cmd_q.op == SWP_OP_CLFS) begin
      prot_err_q <= 1'b0;
    end
  end

  // ********************************************************************
  // core domain: answer and outputs
  // ********************************************************************

  function automatic logic [7:0] swp_status_byte(
    input logic [SWP_CODE_W-1:0] code,
    input logic tb,
    input logic status_write_disable,
    input logic write_enable_latch
  );
    logic [7:0] b;
    b = SWP_BYTE_ZERO;
    b[SWP_SR_B0] = code[0];
    b[SWP_SR_B1] = code[1];
    b[SWP_SR_B2] = code[2];
    b[SWP_SR_B3] = code[3];
    b[SWP_SR_TB] = tb;
    b[SWP_SR_STATUS_WRITE_DISABLE] = status_write_disable;
    b[SWP_SR_WEL] = write_enable_latch;
    return b;
  endfunction : swp_status_byte

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_rsp_q <= '0;
      core_ack_tgl_q <= 1'b0;
    end else if (exec) begin
      core_ack_tgl_q <= !core_ack_tgl_q;
      core_rsp_q.granted <= modify_ok;
      core_rsp_q.refused <= modify_bad || status_write_instr_bad;
      unique case (cmd_q.op)
        SWP_OP_LOCK_READ_INSTR: core_rsp_q.rdata <= {6'h00, cur_lock};
        SWP_OP_RDSR: begin
          core_rsp_q.rdata <= swp_status_byte(prot_code_q,
            top_bottom_select_q, status_write_disable_q,
            write_enable_latch_q);
        end
        SWP_OP_RDFS: begin
          core_rsp_q.rdata <= SWP_BYTE_ZERO;
          core_rsp_q.rdata[SWP_FS_PROT] <= prot_err_q;
        end
        default: core_rsp_q.rdata <= SWP_BYTE_ZERO;
      endcase
    end
  end

  // the array engine sees only sectors that passed both schemes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      modify_grant_out <= 1'b0;
      modify_addr_out <= '0;
      modify_erase_out <= 1'b0;
    end else begin
      modify_grant_out <= modify_ok;
      if (modify_ok) begin
        modify_addr_out <= cmd_q.addr;
        modify_erase_out <= cmd_q.op == SWP_OP_ERAS;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prot_error_out <= 1'b0;
      write_enable_latch_out <= 1'b0;
      status_frozen_out <= 1'b0;
    end else begin
      prot_error_out <= prot_err_q;
      write_enable_latch_out <= write_enable_latch_q;
      status_frozen_out <= sr_frozen;
    end
  end

endmodule : swp_core

/* verilog/swp_pkg.sv */
// shared types, opcodes and field layout of the sector write protection
package swp_pkg;

  localparam int SWP_SECTORS = 128;
  localparam int SWP_SEC_W = 7;
  localparam int SWP_ADDR_W = 23;
  localparam int SWP_SEC_LSB = 16;
  localparam int SWP_SEC_MSB = 22;
  localparam int SWP_CODE_W = 4;
  localparam int SWP_CODE_ALL = 3;

  // lock register bit positions
  localparam int SWP_LR_WLOCK = 0;
  localparam int SWP_LR_LDOWN = 1;

  // status register bit positions
  localparam int SWP_SR_WEL = 1;
  localparam int SWP_SR_B0 = 2;
  localparam int SWP_SR_B1 = 3;
  localparam int SWP_SR_B2 = 4;
  localparam int SWP_SR_TB = 5;
  localparam int SWP_SR_B3 = 6;
  localparam int SWP_SR_STATUS_WRITE_DISABLE = 7;

  // flag status register bit position
  localparam int SWP_FS_PROT = 1;

  localparam logic [1:0] SWP_LR_RESET = 2'h0;
  localparam logic [3:0] SWP_CODE_RESET = 4'h0;
  localparam logic [7:0] SWP_BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    SWP_OP_WRITE_ENABLE_INSTR = 4'h0,
    SWP_OP_WRDI = 4'h1,
    SWP_OP_STATUS_WRITE_INSTR = 4'h2,
    SWP_OP_RDSR = 4'h3,
    SWP_OP_LOCK_READ_INSTR = 4'h4,
    SWP_OP_LOCK_WRITE_INSTR = 4'h5,
    SWP_OP_RDFS = 4'h6,
    SWP_OP_CLFS = 4'h7,
    SWP_OP_PROG = 4'h8,
    SWP_OP_ERAS = 4'h9
  } swp_op_e;

  typedef struct packed {
    swp_op_e op;
    logic [SWP_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } swp_req_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic granted;
    logic refused;
  } swp_rsp_s;

  function automatic logic [SWP_SEC_W-1:0] swp_sector(
    input logic [SWP_ADDR_W-1:0] addr
  );
    return addr[SWP_SEC_MSB:SWP_SEC_LSB];
  endfunction : swp_sector

endpackage : swp_pkg

/* verilog/swp_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module swp_sync
  import swp_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic d_in,
  output logic q_out
);

  logic meta_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule : swp_sync

/* verilog/swp_region.sv */
// block-protect region membership of one sector
`timescale 1ns/10ps
module swp_region
  import swp_pkg::*;
(
  input wire logic [SWP_CODE_W-1:0] code_in,
  input wire logic top_bottom_select_in,
  input wire logic [SWP_SEC_W-1:0] sector_in,
  output logic protected_out
);

  logic [SWP_SEC_W:0] span;
  logic [SWP_SEC_W:0] sec_ext;

  always_comb begin
    sec_ext = {1'b0, sector_in};
    span = '0;
    if (code_in != SWP_CODE_RESET) begin
      span = (SWP_SEC_W+1)'(1) << (code_in[2:0] - 3'h1);
    end
    if (code_in[SWP_CODE_ALL]) begin
      protected_out = 1'b1;
    end else if (code_in == SWP_CODE_RESET) begin
      protected_out = 1'b0;
    end else if (!top_bottom_select_in) begin
      protected_out = sec_ext >= ((SWP_SEC_W+1)'(SWP_SECTORS) - span);
    end else begin
      protected_out = sec_ext < span;
    end
  end

endmodule : swp_region

/* dv/swp_core_assertions.sv */
// port checks for the sector write protection core
`timescale 1ns/10ps
module swp_core_assertions
  import swp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic link_req_valid_in,
  input wire logic link_busy_out,
  input wire logic link_done_out,
  input wire logic modify_grant_out,
  input wire logic prot_error_out,
  input wire logic write_enable_latch_out,
  input wire logic write_protect_n_in,
  input wire logic status_frozen_out
);
  // *****
  // link side
  // *****
  sequence take_s;
    link_req_valid_in && !link_busy_out;
  endsequence
  busy_take_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) take_s |=> link_busy_out)
    else $error("busy not raised after take");
  answer_time_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) take_s |-> ##[3:12] link_done_out)
    else $error("no answer in time");
  done_once_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) link_done_out |=> !link_done_out)
    else $error("done longer than one cycle");
  busy_end_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) $fell(link_busy_out) |-> link_done_out)
    else $error("busy dropped without done");
  // *****
  // core side
  // *****
  grant_pulse_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) modify_grant_out |=> !modify_grant_out)
    else $error("grant longer than one cycle");
  grant_latch_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) modify_grant_out |->
    write_enable_latch_out ##1 !write_enable_latch_out)
    else $error("grant without latch or latch kept");
  // the refused operation's grant slot lies one cycle before the flag shows
  refuse_quiet_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) $rose(prot_error_out) |-> !$past(modify_grant_out))
    else $error("refused operation granted");
  pin_idle_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) write_protect_n_in [*4] |=> !status_frozen_out)
    else $error("frozen while pin released");
endmodule : swp_core_assertions

/* dv/swp_host_model.sv */
// host controller model issuing instructions over the link
`timescale 1ns/10ps
module swp_host_model
  import swp_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic busy_in,
  input wire logic done_in,
  input wire swp_rsp_s rsp_in,
  output logic valid_out,
  output swp_req_s req_out
);
  swp_rsp_s rsp;
  int errs;
  initial begin
    valid_out = 1'b0;
    req_out = '0;
    errs = 0;
  end
  // one request outstanding; released lines are inverted, not left stale
  task automatic xfer(input swp_op_e op, input logic [SWP_ADDR_W-1:0] a,
    input logic [7:0] wd);
    int n;
    @(negedge link_clk_in);
    while (busy_in !== 1'b0) @(negedge link_clk_in);
    valid_out = 1'b1;
    req_out = '{op, a, wd};
    @(negedge link_clk_in);
    valid_out = 1'b0;
    req_out = ~req_out;
    n = 0;
    while (done_in !== 1'b1 && n < 20) begin
      @(negedge link_clk_in);
      n++;
    end
    if (n == 20) errs++;
    rsp = rsp_in;
  endtask : xfer
endmodule : swp_host_model

/* dv/tb_sector_write_protection.sv */
// self-checking bench for the sector write protection core
`timescale 1ns/10ps
module tb_sector_write_protection
  import swp_pkg::*;
;
  logic clk_in, rstn_in, link_clk_in, wp_n, valid;
  logic busy, done, grant, erase, perr, write_enable_latch, frozen;
  logic [SWP_ADDR_W-1:0] gaddr, maddr;
  swp_req_s req;
  swp_rsp_s rsp;
  logic [7:0] rsp_bits;
  assign rsp_bits = {6'h00, rsp.granted, rsp.refused};
  int err_total, n_tests, gcnt, g0;
  // top/bottom, code, sector, writable
  logic [12:0] rows [20] = '{
    {1'h0,4'h1,7'h7F,1'h0}, {1'h0,4'h1,7'h7E,1'h1}, {1'h0,4'h2,7'h7E,1'h0},
    {1'h0,4'h3,7'h7C,1'h0}, {1'h0,4'h3,7'h7B,1'h1}, {1'h0,4'h4,7'h78,1'h0},
    {1'h0,4'h5,7'h6F,1'h1}, {1'h0,4'h6,7'h60,1'h0}, {1'h0,4'h7,7'h3F,1'h1},
    {1'h0,4'h7,7'h40,1'h0}, {1'h0,4'h8,7'h00,1'h0}, {1'h1,4'h0,7'h00,1'h1},
    {1'h1,4'h1,7'h00,1'h0}, {1'h1,4'h2,7'h01,1'h0}, {1'h1,4'h3,7'h03,1'h0},
    {1'h1,4'h3,7'h04,1'h1}, {1'h1,4'h4,7'h07,1'h0}, {1'h1,4'h5,7'h10,1'h1},
    {1'h1,4'h6,7'h1F,1'h0}, {1'h1,4'h7,7'h40,1'h1}};
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #37;
    forever #62.5 link_clk_in = ~link_clk_in;
  end
  swp_core dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .link_clk_in(link_clk_in), .link_req_valid_in(valid), .link_req_in(req),
    .link_busy_out(busy), .link_done_out(done), .link_rsp_out(rsp),
    .write_protect_n_in(wp_n), .modify_grant_out(grant),
    .modify_addr_out(maddr), .modify_erase_out(erase),
    .prot_error_out(perr), .write_enable_latch_out(write_enable_latch),
    .status_frozen_out(frozen));
  swp_host_model host (.link_clk_in(link_clk_in), .busy_in(busy),
    .done_in(done), .rsp_in(rsp), .valid_out(valid), .req_out(req));
  // grant is a single core pulse, so count it rather than poll it;
  // sampled mid-cycle, away from the edge that launches it
  always @(negedge clk_in) begin
    if (grant === 1'b1) begin
      gcnt++;
      gaddr = maddr;
    end
  end
  // *****
  // tasks
  // *****
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input swp_op_e op, input int sec, input logic [7:0] wd);
    host.xfer(op, {sec[6:0], 16'hFFFF}, wd);
  endtask : cmd
  task automatic wr(input swp_op_e op, input int sec, input logic [7:0] wd);
    cmd(SWP_OP_WRITE_ENABLE_INSTR, 0, 8'h00);
    cmd(op, sec, wd);
  endtask : wr
  task automatic do_reset();
    @(negedge clk_in);
    rstn_in = 1'b0;
    repeat (16) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask : do_reset
  task automatic conclude();
    err_total += host.errs;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    conclude();
  end
  // *****
  // main sequence
  // *****
  initial begin
    rstn_in = 1'b0;
    wp_n = 1'b1;
    err_total = 0;
    n_tests = 0;
    gcnt = 0;
    do_reset();
    foreach (rows[i]) begin
      wr(SWP_OP_STATUS_WRITE_INSTR, 0,
        {1'b0, rows[i][11], rows[i][12], rows[i][10:8], 2'h0});
      g0 = gcnt;
      wr(i[0] ? SWP_OP_ERAS : SWP_OP_PROG, int'(rows[i][7:1]), 8'h00);
      check("grant", 8'(gcnt - g0), {7'h00, rows[i][0]});
      check("rsp", rsp_bits, {6'h00, rows[i][0], !rows[i][0]});
      check("perr", {7'h00, perr}, {7'h00, !rows[i][0]});
      if (rows[i][0]) check("erase", {7'h00, erase}, {7'h00, i[0]});
      cmd(SWP_OP_CLFS, 0, 8'h00);
    end
    $display("test region table done");
    wr(SWP_OP_STATUS_WRITE_INSTR, 0, 8'h00);
    wr(SWP_OP_LOCK_WRITE_INSTR, 9, 8'h01);
    check("wel", {7'h00, write_enable_latch}, 8'h00);
    cmd(SWP_OP_LOCK_READ_INSTR, 9, 8'h00);
    check("lock", host.rsp.rdata, 8'h01);
    g0 = gcnt;
    wr(SWP_OP_PROG, 9, 8'h00);
    check("grant", 8'(gcnt - g0), 8'h00);
    check("rsp", rsp_bits, 8'h01);
    check("perr", {7'h00, perr}, 8'h01);
    cmd(SWP_OP_RDFS, 0, 8'h00);
    check("flags", host.rsp.rdata, 8'h02);
    cmd(SWP_OP_CLFS, 0, 8'h00);
    check("perr", {7'h00, perr}, 8'h00);
    g0 = gcnt;
    wr(SWP_OP_PROG, 8, 8'h00);
    check("grant", 8'(gcnt - g0), 8'h01);
    check("sector", {1'b0, gaddr[22:16]}, 8'h08);
    cmd(SWP_OP_WRITE_ENABLE_INSTR, 0, 8'h00);
    check("wel", {7'h00, write_enable_latch}, 8'h01);
    cmd(SWP_OP_WRDI, 0, 8'h00);
    check("wel", {7'h00, write_enable_latch}, 8'h00);
    cmd(SWP_OP_LOCK_WRITE_INSTR, 9, 8'h00);
    cmd(SWP_OP_LOCK_READ_INSTR, 9, 8'h00);
    check("lock", host.rsp.rdata, 8'h01);
    wr(SWP_OP_LOCK_WRITE_INSTR, 20, 8'h02);
    wr(SWP_OP_LOCK_WRITE_INSTR, 9, 8'h03);
    wr(SWP_OP_LOCK_WRITE_INSTR, 9, 8'h00);
    wr(SWP_OP_LOCK_WRITE_INSTR, 20, 8'h01);
    cmd(SWP_OP_LOCK_READ_INSTR, 9, 8'h00);
    check("lock", host.rsp.rdata, 8'h03);
    cmd(SWP_OP_LOCK_READ_INSTR, 20, 8'h00);
    check("lock", host.rsp.rdata, 8'h02);
    g0 = gcnt;
    wr(SWP_OP_PROG, 20, 8'h00);
    check("grant", 8'(gcnt - g0), 8'h01);
    $display("test lock registers done");
    wr(SWP_OP_STATUS_WRITE_INSTR, 0, 8'h84);
    @(negedge clk_in);
    wp_n = 1'b0;
    repeat (6) @(negedge clk_in);
    check("frozen", {7'h00, frozen}, 8'h01);
    wr(SWP_OP_STATUS_WRITE_INSTR, 0, 8'h00);
    check("perr", {7'h00, perr}, 8'h01);
    check("rsp", rsp_bits, 8'h01);
    cmd(SWP_OP_RDSR, 0, 8'h00);
    check("status", host.rsp.rdata, 8'h84);
    cmd(SWP_OP_CLFS, 0, 8'h00);
    @(negedge clk_in);
    wp_n = 1'b1;
    repeat (6) @(negedge clk_in);
    wr(SWP_OP_STATUS_WRITE_INSTR, 0, 8'h00);
    cmd(SWP_OP_RDSR, 0, 8'h00);
    check("status", host.rsp.rdata, 8'h00);
    $display("test frozen status done");
    do_reset();
    check("wel", {7'h00, write_enable_latch}, 8'h00);
    check("frozen", {7'h00, frozen}, 8'h00);
    cmd(SWP_OP_LOCK_READ_INSTR, 9, 8'h00);
    check("lock", host.rsp.rdata, 8'h00);
    $display("test power-up done");
    conclude();
  end
endmodule : tb_sector_write_protection

bind swp_core swp_core_assertions u_chk (.clk_in, .rstn_in, .link_clk_in,
  .link_req_valid_in, .link_busy_out, .link_done_out, .modify_grant_out,
  .prot_error_out, .write_enable_latch_out, .write_protect_n_in,
  .status_frozen_out);
